/* verilog/lsnp_pkg.sv */
/*
  Constants for the lane sample nibble packer: sample widths, lane modes,
  frame sizes. Assumes a single 100 MHz system clock.
*/
package lsnp_pkg;
  localparam int MAX_CONV = 8;
  localparam int MAX_RES = 16;
  localparam int FRAME_BITS = MAX_CONV * MAX_RES;
  localparam int OCT_W = 8;
  localparam int MAX_OCTETS = FRAME_BITS / OCT_W;
  localparam int OCT_CNT_W = 5;
  localparam int BUF_DEPTH = 2;
  // Lane mode codes: converters per lane
  localparam logic [1:0] LANE_TWO = 2'h0;
  localparam logic [1:0] LANE_FOUR = 2'h1;
  localparam logic [1:0] LANE_EIGHT = 2'h2;
  // Width codes for resolution and serialized width
  localparam logic [1:0] WID_10 = 2'h0;
  localparam logic [1:0] WID_12 = 2'h1;
  localparam logic [1:0] WID_14 = 2'h2;
  localparam logic [1:0] WID_16 = 2'h3;
  typedef enum logic [0:0] {LSNP_IDLE, LSNP_SEND} lsnp_state_t;
endpackage

/* verilog/lsnp_skid_buf.sv */
/*
  Two-entry buffer with valid/ready on both sides.
  Assumes both sides run on clk_sys.
*/
`timescale 1ns/1ns
module lsnp_skid_buf #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [$clog2(DEPTH):0] cnt_ff;
  logic [$clog2(DEPTH)-1:0] wrPtr_ff;
  logic [$clog2(DEPTH)-1:0] rdPtr_ff;
  wire push = inValid && inReady;
  wire pop = outValid && outReady;

  assign inReady = (cnt_ff != DEPTH[$clog2(DEPTH):0]);
  assign outValid = (cnt_ff != '0);
  assign outData = mem_ff[rdPtr_ff];

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_ff[wrPtr_ff] <= inData;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      cnt_ff <= '0;
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
    end else begin
      if (push) begin
        wrPtr_ff <= wrPtr_ff + 1'b1;
      end
      if (pop) begin
        rdPtr_ff <= rdPtr_ff + 1'b1;
      end
      cnt_ff <= cnt_ff + {{$clog2(DEPTH){1'b0}}, push}
        - {{$clog2(DEPTH){1'b0}}, pop};
    end
  end
endmodule

/* verilog/lsnp_packer.sv */
/*
  Lane sample nibble packer: takes one frame of converter samples and emits
  the lane octets in normal packing mode, through a two-entry buffer.
  Assumes samples are MSB-aligned in 16-bit slots and mode inputs stay
  steady while a frame is being sent.
*/
`timescale 1ns/1ns
module lsnp_packer
  import lsnp_pkg::*;
#(
  parameter int NUM_CONV = lsnp_pkg::MAX_CONV
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [1:0] convPerLane,
  input wire logic [1:0] resolutionSetting,
  input wire logic [1:0] serialWidthSetting,
  input wire logic frameValid,
  input wire logic [lsnp_pkg::FRAME_BITS-1:0] frameSamples,
  output logic frameReady_ff,
  output logic octetValid_ff,
  output logic [lsnp_pkg::OCT_W-1:0] octetData_ff,
  output logic octetLast_ff,
  input wire logic octetReady
);
  import lsnp_pkg::*;

  // ------------------------------------------------------------
  // Width decoding
  // ------------------------------------------------------------
  function automatic logic [4:0] widBits(input logic [1:0] code);
    case (code)
      WID_10: widBits = 5'h0a;
      WID_12: widBits = 5'h0c;
      WID_14: widBits = 5'h0e;
      default: widBits = 5'h10;
    endcase
  endfunction

  wire [4:0] resBits = widBits(resolutionSetting);
  wire [4:0] serBits = widBits(serialWidthSetting);
  // Two-converter lanes always round up to 12 or 16 bits
  wire [4:0] twoBits = (resBits > 5'h0c) ? 5'h10 : 5'h0c;
  // Serialized width never below resolution, so clamp a bad setting
  wire [4:0] serClamp = (serBits < resBits) ? resBits : serBits;
  // Code 3 falls back to the full two-converter layout
  wire twoMode = (convPerLane != LANE_FOUR) && (convPerLane != LANE_EIGHT);
  wire [4:0] wordBits = twoMode ? twoBits : serClamp;
  wire [3:0] numConv = (convPerLane == LANE_EIGHT) ? 4'h8 :
    (convPerLane == LANE_FOUR) ? 4'h4 : 4'h2;
  wire [7:0] usedBits = {3'h0, wordBits} * {4'h0, numConv};
  // Round up to whole octets; remainder becomes zero tail
  wire [4:0] numOctets = 5'((usedBits + 8'h07) >> 3);

  // ------------------------------------------------------------
  // Frame assembly: padded words concatenated MSB first
  // ------------------------------------------------------------
  logic [FRAME_BITS-1:0] padWord [NUM_CONV];
  logic [FRAME_BITS-1:0] packedFrame;
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CONV; gi++) begin : g_word
      wire [MAX_RES-1:0] raw = frameSamples[FRAME_BITS-1-gi*MAX_RES -:
        MAX_RES];
      // Keep top resBits; low bits forced to zero as LSB padding
      wire [MAX_RES-1:0] keepMask = ~(16'hffff >> resBits);
      wire [MAX_RES-1:0] padded = raw & keepMask;
      wire [7:0] offs = 8'(wordBits * gi);
      // Converter gi starts at bit offset gi*wordBits from the top
      assign padWord[gi] = (gi < numConv) ?
        ({padded, {(FRAME_BITS-MAX_RES){1'b0}}} >> offs) : '0;
    end
  endgenerate

  always_comb begin
    packedFrame = '0;
    for (int i = 0; i < NUM_CONV; i++) begin
      packedFrame = packedFrame | padWord[i];
    end
  end

  // ------------------------------------------------------------
  // Octet sequencer
  // ------------------------------------------------------------
  lsnp_state_t state_ff;
  lsnp_state_t nxt_state;
  logic [FRAME_BITS-1:0] shift_ff;
  logic [FRAME_BITS-1:0] nxt_shift;
  logic [OCT_CNT_W-1:0] left_ff;
  logic [OCT_CNT_W-1:0] nxt_left;
  logic bufInReady;
  logic bufOutValid;
  logic [OCT_W:0] bufOutData;

  wire sending = (state_ff == LSNP_SEND);
  wire push = sending && bufInReady;
  wire lastOct = (left_ff == 5'h01);
  // Take only once ready shows, so the edge after reset takes nothing
  wire takeFrame = (state_ff == LSNP_IDLE) && frameValid && frameReady_ff;
  // One octet pops only when the output register is free to load
  wire outFree = !octetValid_ff || octetReady;

  always_comb begin
    nxt_state = state_ff;
    nxt_shift = shift_ff;
    nxt_left = left_ff;
    case (state_ff)
      LSNP_IDLE: begin
        if (takeFrame) begin
          nxt_state = LSNP_SEND;
          nxt_shift = packedFrame;
          nxt_left = numOctets;
        end
      end
      LSNP_SEND: begin
        if (push) begin
          nxt_shift = shift_ff << OCT_W;
          nxt_left = left_ff - 5'h01;
          if (lastOct) begin
            nxt_state = LSNP_IDLE;
          end
        end
      end
      default: nxt_state = LSNP_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      state_ff <= LSNP_IDLE;
      shift_ff <= '0;
      left_ff <= '0;
      frameReady_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      shift_ff <= nxt_shift;
      left_ff <= nxt_left;
      frameReady_ff <= (nxt_state == LSNP_IDLE) && !takeFrame;
    end
  end

  // Stall by the receiver backs up into the buffer, not lost
  lsnp_skid_buf #(
    .WIDTH(OCT_W + 1),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .inValid(sending),
    .inReady(bufInReady),
    .inData({lastOct, shift_ff[FRAME_BITS-1 -: OCT_W]}),
    .outValid(bufOutValid),
    .outReady(outFree),
    .outData(bufOutData)
  );

  // ------------------------------------------------------------
  // Registered outputs
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      octetValid_ff <= 1'b0;
      octetData_ff <= 8'h00;
      octetLast_ff <= 1'b0;
    end else if (outFree) begin
      octetValid_ff <= bufOutValid;
      octetData_ff <= bufOutValid ? bufOutData[OCT_W-1:0] : 8'h00;
      octetLast_ff <= bufOutValid && bufOutData[OCT_W];
    end
  end
endmodule

/* tb/lsnp_packer_properties.sv */
/* Port checker for the packer.
   Bound to lsnp_packer; one clock, synchronous reset. */
`timescale 1ns/1ns
module lsnp_packer_properties
  import lsnp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [1:0] convPerLane,
  input wire logic [1:0] resolutionSetting,
  input wire logic [1:0] serialWidthSetting,
  input wire logic frameValid,
  input wire logic [lsnp_pkg::FRAME_BITS-1:0] frameSamples,
  input wire logic frameReady_ff,
  input wire logic octetValid_ff,
  input wire logic [lsnp_pkg::OCT_W-1:0] octetData_ff,
  input wire logic octetLast_ff,
  input wire logic octetReady
);
  logic [4:0] octCnt_ff;
  int word;
  int nOct;
  wire accept = octetValid_ff && octetReady;
  wire four = convPerLane == LANE_FOUR;
  wire eight = convPerLane == LANE_EIGHT;
  always_comb begin
    word = (four || eight) ? 10 + 2 * ((serialWidthSetting > resolutionSetting)
      ? serialWidthSetting : resolutionSetting) : (resolutionSetting > WID_12
      ? 16 : 12);
    nOct = (word * (eight ? 8 : four ? 4 : 2) + 7) / 8;
  end
  // Counts accepted octets of the current frame
  always_ff @(posedge clk_sys) begin
    if (!nrst || (accept && octetLast_ff)) octCnt_ff <= 5'h0;
    else if (accept) octCnt_ff <= octCnt_ff + 5'h1;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  sequence takeSeq;
    frameValid && frameReady_ff;
  endsequence
  reset_quiet_a: assert property (disable iff (1'b0) !nrst |=> !frameReady_ff
    && !octetValid_ff && !octetLast_ff) else $error("outputs live in reset");
  ready_release_a: assert property ($rose(nrst) |=> frameReady_ff)
    else $error("not ready after reset");
  take_busy_a: assert property (takeSeq |=> !frameReady_ff)
    else $error("still ready after take");
  // Only from an idle, empty output; a queued octet would delay the answer
  first_octet_a: assert property (takeSeq and (!octetValid_ff
    && $past(frameReady_ff)) |-> ##3 octetValid_ff
    && octetData_ff == $past(frameSamples[127:120], 3))
    else $error("first octet wrong or late");
  stall_hold_a: assert property (octetValid_ff && !octetReady |=>
    octetValid_ff && $stable(octetData_ff) && $stable(octetLast_ff))
    else $error("octet changed while stalled");
  idle_zero_a: assert property (!octetValid_ff |->
    octetData_ff == 8'h00 && !octetLast_ff)
    else $error("data while not valid");
  octet_count_a: assert property (
    accept && octetLast_ff |-> int'(octCnt_ff) + 1 == nOct)
    else $error("wrong frame length");
  no_overrun_a: assert property (accept && !octetLast_ff |->
    int'(octCnt_ff) + 1 < nOct) else $error("last octet missing");
endmodule
bind lsnp_packer lsnp_packer_properties chk_u (.*);

/* tb/lsnp_sink_model.sv */
/* Receiving link logic: accepts octets, promptly or with stalls.
   Assumes clk_sys shared with the packer. */
`timescale 1ns/1ns
module lsnp_sink_model (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic slowMode,
  output logic octetReady
);
  logic [1:0] phase_ff;
  initial octetReady = 1'b0;
  // Slow: ready one cycle in four, enough to fill the buffer
  always @(posedge clk_sys) begin
    phase_ff <= nrst ? phase_ff + 2'h1 : 2'h0;
    octetReady <= #1 !slowMode || phase_ff == 2'h3;
  end
endmodule

/* tb/testbench.sv */
/* Bench: packs frames in every lane mode, judges each octet.
   Assumes the packer, its checker and the sink model. */
`timescale 1ns/1ns
module testbench;
  import lsnp_pkg::*;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [1:0] convPerLane = 2'h0;
  logic [1:0] resolutionSetting = 2'h0;
  logic [1:0] serialWidthSetting = 2'h0;
  logic frameValid = 1'b0;
  logic slowMode = 1'b0;
  logic [FRAME_BITS-1:0] frameSamples = '0;
  logic frameReady_ff, octetValid_ff, octetLast_ff, octetReady;
  logic [OCT_W-1:0] octetData_ff;
  int err_count = 0;
  int total_checks = 0;
  int cycles = 0;
  lsnp_packer dut_u (.*);
  lsnp_sink_model sink_u (.clk_sys(clk_sys), .nrst(nrst),
    .slowMode(slowMode), .octetReady(octetReady));
  initial forever #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      final_report();
    end
  end
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic check8(input string what, input logic [7:0] exp,
    input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic pack_frame(input logic [1:0] c, r, s, input logic [127:0] smp);
    logic [127:0] stream;
    logic [15:0] w;
    int word, n, nOct, i;
    stream = '0;
    n = (c == LANE_EIGHT) ? 8 : (c == LANE_FOUR) ? 4 : 2;
    word = (n == 2) ? (r > WID_12 ? 16 : 12) : 10 + 2 * (s > r ? s : r);
    for (i = 0; i < n; i++) begin
      w = smp[127 - 16 * i -: 16] & ~(16'hffff >> (10 + 2 * r));
      stream = stream | ({w, 112'h0} >> (i * word));
    end
    nOct = (n * word + 7) / 8;
    convPerLane = c;
    resolutionSetting = r;
    serialWidthSetting = s;
    frameSamples = smp;
    frameValid = 1'b1;
    while (frameReady_ff !== 1'b1) begin
      @(posedge clk_sys);
      #1;
    end
    @(posedge clk_sys);
    #1 frameValid = 1'b0;
    i = 0;
    while (i < nOct) begin
      @(posedge clk_sys);
      #2;
      if (octetValid_ff === 1'b1 && octetReady === 1'b1) begin
        check8("octet", stream[127-8*i -: 8], octetData_ff);
        check8("last", {7'h0, i == nOct - 1}, {7'h0, octetLast_ff});
        i++;
      end
    end
    @(posedge clk_sys);
    #1;
  endtask
  // Prompt sink, every lane code and width pair, clamped widths too
  task automatic all_modes();
    logic [127:0] smp;
    for (int c = 0; c < 4; c++)
      for (int r = 0; r < 4; r++)
        for (int s = 0; s < 4; s++) begin
          smp = {4{32'h9e37_79b9}} ^ (128'h1 << (c * 16 + r * 4 + s));
          pack_frame(c[1:0], r[1:0], s[1:0], smp);
        end
  endtask
  // All-ones samples expose any padding bit left high; these frames have no tail
  task automatic stalled_sink();
    slowMode = 1'b1;
    pack_frame(LANE_EIGHT, WID_14, WID_16, '1);
    pack_frame(LANE_FOUR, WID_10, WID_12, '1);
    pack_frame(LANE_TWO, WID_10, WID_10, '1);
    slowMode = 1'b0;
  endtask
  initial begin
    repeat (5) @(posedge clk_sys);
    #1 nrst = 1'b1;
    all_modes();
    stalled_sink();
    final_report();
  end
endmodule
